/* File: cpb_params.svh */
// Purpose: constants of the code prefetch and branch target cache block
// Assumes: one clock (mclk, 40 MHz), synchronous active-high reset
// Notes: types live in cpb_pkg
// Overview of operation
// - queue fetches code whenever bus is idle and queue has room
// - fetch only needed bytes, no dummy reads
// - queue holds at most six bytes
// - branch miss flushes queue, refetches, execution stalls
// - four entries compared in parallel per branch
// - entry keeps destination plus six code bytes
// - hit moves stored bytes into queue at once
// - queue and cache enabled after reset
// - bus control write can disable both
// - memory accesses take programmable wait states
// - data shares code waits unless split
// - machine cycle four clocks, fetch overlaps execution
// - cycles per instruction as classic core
// - two queued bytes delivered in one cycle
// - fetching continues during internal execution cycles
`ifndef CPB_PARAMS_SVH
`define CPB_PARAMS_SVH
`define CPB_QUEUE_DEPTH 6
`define CPB_CACHE_ENTRIES 4
`define CPB_WAIT_RESET 3'h4
`define CPB_WAIT_MIN 3'h1
`define CPB_CLK_PERIOD_NS 25
`define CPB_MCYCLE_NS 100
`define CPB_MCYCLE_CLKS (`CPB_MCYCLE_NS / `CPB_CLK_PERIOD_NS)
`endif

/* File: cpb_pkg.sv */
// Purpose: shared types of the prefetch block
// Assumes: nothing
// Notes: bus states differ in one bit along idle-code and in two bits along idle-data
package cpb_pkg;
    typedef enum logic [1:0] {
        CPB_IDLE = 2'h0,
        CPB_CODE = 2'h1,
        CPB_DATA = 2'h3
    } cpb_bus_t;
endpackage

/* File: cpb_branch_cache.sv */
// Purpose: fully associative branch target cache
// Assumes: fill bytes arrive in address order after an allocation
// Notes: no snooping, code written at run time can leave stale entries
`include "cpb_params.svh"
module cpb_branch_cache #(
    parameter int ENTRIES = `CPB_CACHE_ENTRIES,
    parameter int BYTES = `CPB_QUEUE_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // lookup
    input wire logic lookupEn,
    input wire logic [15:0] lookupAddr,
    output logic hit,
    output logic [BYTES-1:0][7:0] hitData,
    output logic [2:0] hitCount,
    // allocation and fill
    input wire logic allocEn,
    input wire logic abortFill,
    input wire logic fillEn,
    input wire logic [7:0] fillByte
);
    localparam int IW = $clog2(ENTRIES);
    localparam logic [2:0] LAST = 3'(BYTES - 1);

    generate
        if (ENTRIES < 2 || (1 << IW) != ENTRIES || BYTES < 1 || BYTES > 7) begin : g_chk
            $error("cpb_branch_cache: unsupported geometry");
        end
    endgenerate

    typedef struct packed {
        logic [ENTRIES-1:0] valid;
        logic [ENTRIES-1:0][15:0] tag;
        logic [ENTRIES-1:0][2:0] cnt;
        logic [ENTRIES-1:0][BYTES-1:0][7:0] data;
        logic [IW-1:0] victim;
        logic [IW-1:0] fillIdx;
        logic filling;
    } cpb_cache_t;

    cpb_cache_t r;
    cpb_cache_t next_r;

    // all tags compared at once; empty entries never hit
    always_comb begin
        hit = 1'b0;
        hitData = '0;
        hitCount = 3'h0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (lookupEn && r.valid[i] && r.cnt[i] != 3'h0 && r.tag[i] == lookupAddr) begin
                hit = 1'b1;
                hitData = r.data[i];
                hitCount = r.cnt[i];
            end
        end
    end

    always_comb begin
        next_r = r;
        if (allocEn) begin
            next_r.valid[r.victim] = 1'b1;
            next_r.tag[r.victim] = lookupAddr;
            next_r.cnt[r.victim] = 3'h0;
            next_r.fillIdx = r.victim;
            next_r.filling = 1'b1;
            next_r.victim = IW'(r.victim + 1'b1);
        end else if (abortFill) begin
            next_r.filling = 1'b0;
        end else if (fillEn && r.filling) begin
            next_r.data[r.fillIdx][r.cnt[r.fillIdx]] = fillByte;
            next_r.cnt[r.fillIdx] = r.cnt[r.fillIdx] + 3'h1;
            if (r.cnt[r.fillIdx] == LAST) begin
                next_r.filling = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    victimStep_a: assert property (@(posedge mclk) disable iff (rst)
        allocEn |=> r.victim == IW'($past(r.victim) + 1'b1))
        else $error("victim pointer did not advance on allocation");
    fillStop_a: assert property (@(posedge mclk) disable iff (rst)
        r.filling |-> r.cnt[r.fillIdx] <= LAST)
        else $error("cache entry filled beyond its byte count");
endmodule

/* File: cpb_fetch_unit.sv */
// Purpose: code prefetch queue with branch target cache and memory wait control
// Assumes: execution unit, branch and data requests share mclk; memory returns
//          read data in the last cycle of an access
// Notes: bus control fields are plain ports loaded by a write strobe
`include "cpb_params.svh"
module cpb_fetch_unit #(
    parameter int DEPTH = `CPB_QUEUE_DEPTH,
    parameter int ENTRIES = `CPB_CACHE_ENTRIES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // bus control register
    input wire logic busCtlWrite,
    input wire logic busCtlDisable,
    input wire logic busCtlSplit,
    input wire logic [2:0] busCtlCodeWait,
    input wire logic [2:0] busCtlDataWait,
    // execution unit: queue side
    input wire logic take,
    input wire logic takeTwo,
    input wire logic branchReq,
    input wire logic [15:0] branchAddr,
    output logic [7:0] qByte0,
    output logic [7:0] qByte1,
    output logic [2:0] qCount,
    output logic mcycEn,
    output logic enabled,
    // execution unit: data access
    input wire logic dataReq,
    input wire logic dataWe,
    input wire logic [15:0] dataAddr,
    input wire logic [7:0] dataWdata,
    output logic dataAck,
    output logic [7:0] dataRdata,
    // module memory
    output logic memReq,
    output logic memWe,
    output logic [15:0] memAddr,
    output logic [7:0] memWdata,
    input wire logic [7:0] memRdata
);
    localparam logic [2:0] DEPTH_C = 3'(DEPTH);
    localparam logic [1:0] MC_LAST = 2'(`CPB_MCYCLE_CLKS - 1);

    generate
        if (DEPTH < 2 || DEPTH > 7 || `CPB_MCYCLE_CLKS != 4) begin : g_chk
            $error("cpb_fetch_unit: unsupported depth or machine cycle");
        end
    endgenerate

    typedef struct packed {
        cpb_pkg::cpb_bus_t st;
        logic [2:0] waitCnt;
        logic stale;
        logic [15:0] pc;
        logic [DEPTH-1:0][7:0] q;
        logic [2:0] qCnt;
        logic enable;
        logic split;
        logic [2:0] codeWait;
        logic [2:0] dataWait;
        logic memReq;
        logic memWe;
        logic [15:0] memAddr;
        logic [7:0] memWdata;
        logic dataAck;
        logic [7:0] dataRdata;
        logic [1:0] divCnt;
        logic mcycEn;
    } cpb_fetch_t;

    cpb_fetch_t r;
    cpb_fetch_t next_r;
    logic hit;
    logic [DEPTH-1:0][7:0] hitData;
    logic [2:0] hitCount;
    logic allocEn;
    logic abortFill;
    logic fillEn;
    logic fetchOk;
    logic [2:0] tk;

    // zero waits would make a zero-length access, so it is served as one
    function automatic logic [2:0] cpbWaits(input logic [2:0] w);
        return (w == 3'h0) ? `CPB_WAIT_MIN : w;
    endfunction

    cpb_branch_cache #(
        .ENTRIES(ENTRIES),
        .BYTES(DEPTH)
    ) u_cache (
        .mclk(mclk),
        .rst(rst),
        .lookupEn(branchReq && r.enable),
        .lookupAddr(branchAddr),
        .hit(hit),
        .hitData(hitData),
        .hitCount(hitCount),
        .allocEn(allocEn),
        .abortFill(abortFill),
        .fillEn(fillEn),
        .fillByte(memRdata)
    );

    // disabled queue keeps one byte only, fetched when empty
    assign fetchOk = r.enable ? (r.qCnt < DEPTH_C) : (r.qCnt == 3'h0);

    always_comb begin
        next_r = r;
        allocEn = 1'b0;
        abortFill = 1'b0;
        fillEn = 1'b0;
        tk = 3'h0;
        next_r.dataAck = 1'b0;
        next_r.divCnt = 2'(r.divCnt + 2'h1);
        next_r.mcycEn = (r.divCnt == MC_LAST - 2'h1);
        if (busCtlWrite) begin
            next_r.enable = !busCtlDisable;
            next_r.split = busCtlSplit;
            next_r.codeWait = busCtlCodeWait;
            next_r.dataWait = busCtlDataWait;
        end
        if (take && !branchReq) begin
            tk = takeTwo ? 3'h2 : 3'h1;
        end
        if (tk > r.qCnt) begin
            tk = 3'h0;
        end
        for (int i = 0; i < DEPTH; i++) begin
            next_r.q[i] = (i + int'(tk) < DEPTH) ? r.q[i + int'(tk)] : 8'h00;
        end
        next_r.qCnt = r.qCnt - tk;
        unique case (r.st)
            cpb_pkg::CPB_IDLE: begin
                if (dataReq && !r.dataAck) begin
                    next_r.st = cpb_pkg::CPB_DATA;
                    next_r.memReq = 1'b1;
                    next_r.memWe = dataWe;
                    next_r.memAddr = dataAddr;
                    next_r.memWdata = dataWdata;
                    next_r.waitCnt = cpbWaits(r.split ? r.dataWait : r.codeWait);
                end else if (fetchOk && !branchReq) begin
                    next_r.st = cpb_pkg::CPB_CODE;
                    next_r.memReq = 1'b1;
                    next_r.memWe = 1'b0;
                    next_r.memAddr = r.pc;
                    next_r.waitCnt = cpbWaits(r.codeWait);
                end
            end
            cpb_pkg::CPB_CODE, cpb_pkg::CPB_DATA: begin
                if (r.waitCnt == 3'h1) begin
                    next_r.st = cpb_pkg::CPB_IDLE;
                    next_r.memReq = 1'b0;
                    next_r.memWe = 1'b0;
                    next_r.stale = 1'b0;
                    if (r.st == cpb_pkg::CPB_DATA) begin
                        next_r.dataAck = 1'b1;
                        next_r.dataRdata = memRdata;
                    end else if (!r.stale && !branchReq) begin
                        next_r.q[next_r.qCnt] = memRdata;
                        next_r.qCnt = next_r.qCnt + 3'h1;
                        next_r.pc = r.pc + 16'h0001;
                        fillEn = 1'b1;
                    end
                end else begin
                    next_r.waitCnt = r.waitCnt - 3'h1;
                end
            end
            default: begin
                next_r.st = cpb_pkg::CPB_IDLE;
                next_r.memReq = 1'b0;
            end
        endcase
        if (branchReq) begin
            // an in-flight fetch of the old stream is finished but dropped
            next_r.stale = (r.st == cpb_pkg::CPB_CODE) && (r.waitCnt != 3'h1);
            abortFill = 1'b1;
            if (hit) begin
                next_r.q = hitData;
                next_r.qCnt = hitCount;
                next_r.pc = branchAddr + {13'h0000, hitCount};
            end else begin
                next_r.qCnt = 3'h0;
                next_r.pc = branchAddr;
                allocEn = r.enable;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '0;
            r.enable <= 1'b1;
            r.codeWait <= `CPB_WAIT_RESET;
            r.dataWait <= `CPB_WAIT_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign qByte0 = r.q[0];
    assign qByte1 = r.q[1];
    assign qCount = r.qCnt;
    assign mcycEn = r.mcycEn;
    assign enabled = r.enable;
    assign dataAck = r.dataAck;
    assign dataRdata = r.dataRdata;
    assign memReq = r.memReq;
    assign memWe = r.memWe;
    assign memAddr = r.memAddr;
    assign memWdata = r.memWdata;

    // access length checker
    logic [3:0] accLen;
    logic [2:0] expLen;
    logic codeDone;
    // a live code fetch ends this cycle and adds its byte
    assign codeDone = (r.st == cpb_pkg::CPB_CODE) && (r.waitCnt == 3'h1) && !r.stale;
    always_ff @(posedge mclk) begin
        if (rst) begin
            accLen <= 4'h0;
            expLen <= 3'h0;
        end else begin
            accLen <= memReq ? accLen + 4'h1 : 4'h0;
            if (memReq && accLen == 4'h0) begin
                expLen <= r.waitCnt;
            end
        end
    end

    queueBound_a: assert property (@(posedge mclk) disable iff (rst)
        qCount <= DEPTH_C)
        else $error("queue holds more bytes than its depth");
    noDummy_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(memReq) && r.st == cpb_pkg::CPB_CODE |-> $past(fetchOk))
        else $error("code fetch started without room for the byte");
    idleFetch_a: assert property (@(posedge mclk) disable iff (rst)
        r.st == cpb_pkg::CPB_IDLE && fetchOk && !branchReq && !dataReq
        |=> memReq && !memWe && memAddr == $past(r.pc))
        else $error("idle bus not used for prefetch");
    codeWait_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(memReq) && r.st == cpb_pkg::CPB_CODE
        |-> r.waitCnt == cpbWaits($past(r.codeWait)))
        else $error("code fetch used wrong wait count");
    dataWait_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(memReq) && r.st == cpb_pkg::CPB_DATA
        |-> r.waitCnt == cpbWaits($past(r.split) ? $past(r.dataWait) : $past(r.codeWait)))
        else $error("data access used wrong wait count");
    accessLen_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(memReq) |-> accLen == {1'b0, expLen})
        else $error("memory access length differs from wait count");
    branchFlush_a: assert property (@(posedge mclk) disable iff (rst)
        branchReq && !hit |=> qCount == 3'h0 ##1 qCount == 3'h0)
        else $error("queue not flushed on branch miss");
    hitLoad_a: assert property (@(posedge mclk) disable iff (rst)
        branchReq && hit |=> qCount == $past(hitCount) && qByte0 == $past(hitData[0]))
        else $error("cache hit did not load the queue");
    resetOn_a: assert property (@(posedge mclk)
        $past(rst) |-> enabled && r.codeWait == `CPB_WAIT_RESET)
        else $error("queue or cache not enabled after reset");
    ctlOff_a: assert property (@(posedge mclk) disable iff (rst)
        busCtlWrite && busCtlDisable |=> !enabled)
        else $error("bus control write did not disable prefetch");
    mcycle_a: assert property (@(posedge mclk) disable iff (rst)
        mcycEn |=> !mcycEn [*3] ##1 mcycEn)
        else $error("machine cycle is not four clocks");
    takeTwo_a: assert property (@(posedge mclk) disable iff (rst)
        take && takeTwo && !branchReq && qCount >= 3'h2
        |=> qCount == $past(qCount) - 3'h2 + {2'h0, $past(codeDone)})
        else $error("two-byte take did not consume two bytes");

    hitSeen_c: cover property (@(posedge mclk) disable iff (rst) branchReq && hit);
    queueFull_c: cover property (@(posedge mclk) disable iff (rst) qCount == DEPTH_C);
    dataDone_c: cover property (@(posedge mclk) disable iff (rst) dataAck);
    pairTake_c: cover property (@(posedge mclk) disable iff (rst)
        take && takeTwo && qCount >= 3'h2 && memReq);
endmodule

/* File: cpb_mem_model.sv */
// Purpose: program and data memory behind the fetch unit
// Assumes: one byte per address, low address byte selects the cell
// Notes: read data is only valid while an access is active; idle drives the inverse of the last read
module cpb_mem_model (
    // clock
    input wire logic mclk,
    // access from the fetch unit
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [15:0] memAddr,
    input wire logic [7:0] memWdata,
    output logic [7:0] memRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cells [256];
    logic [7:0] lastRd;
    initial begin
        for (int i = 0; i < 256; i++) begin
            cells[i] = 8'(i) ^ 8'h5A;
        end
        lastRd = 8'h00;
    end
    // idle bus shows the inverse so a stale byte can never match
    assign memRdata = memReq ? cells[memAddr[7:0]] : ~lastRd;
    always @(posedge mclk) begin
        if (memReq) begin
            lastRd <= cells[memAddr[7:0]];
        end
        if (memReq && memWe) begin
            cells[memAddr[7:0]] <= memWdata;
        end
    end
endmodule

/* File: code_prefetch_branch_cache_bench.sv */
// Purpose: self-checking bench of the prefetch queue and branch target cache
// Assumes: inputs change at the falling edge, outputs judged there
// Notes: data tests run with a full queue so no code fetch shares the bus
module code_prefetch_branch_cache_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic busCtlWrite = 1'b0, busCtlDisable = 1'b0, busCtlSplit = 1'b0;
    logic [2:0] busCtlCodeWait = 3'h4, busCtlDataWait = 3'h4;
    logic take = 1'b0, takeTwo = 1'b0, branchReq = 1'b0;
    logic [15:0] branchAddr = 16'h0000;
    logic dataReq = 1'b0, dataWe = 1'b0;
    logic [15:0] dataAddr = 16'h0000;
    logic [7:0] dataWdata = 8'h00;
    logic [7:0] qByte0, qByte1, dataRdata, memWdata, memRdata;
    logic [2:0] qCount;
    logic mcycEn, enabled, dataAck, memReq, memWe;
    logic [15:0] memAddr;
    int badCount = 0;
    int nChecks = 0;
    always #12.5 mclk = ~mclk;
    cpb_fetch_unit #(.DEPTH(6), .ENTRIES(4)) u_cpb_fetch_unit (
        .mclk(mclk), .rst(rst), .busCtlWrite(busCtlWrite), .busCtlDisable(busCtlDisable),
        .busCtlSplit(busCtlSplit), .busCtlCodeWait(busCtlCodeWait),
        .busCtlDataWait(busCtlDataWait), .take(take), .takeTwo(takeTwo),
        .branchReq(branchReq), .branchAddr(branchAddr), .qByte0(qByte0), .qByte1(qByte1),
        .qCount(qCount), .mcycEn(mcycEn), .enabled(enabled), .dataReq(dataReq),
        .dataWe(dataWe), .dataAddr(dataAddr), .dataWdata(dataWdata), .dataAck(dataAck),
        .dataRdata(dataRdata), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
        .memWdata(memWdata), .memRdata(memRdata));
    cpb_mem_model u_cpb_mem_model (.mclk(mclk), .memReq(memReq), .memWe(memWe),
        .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata));

    function automatic logic [7:0] codeAt(input logic [15:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction
    task automatic printVerdict();
        if (badCount == 0 && nChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        nChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic hang(input string msg);
        badCount++;
        $display("BAD %0t wait ran out: %s", $time, msg);
        printVerdict();
    endtask
    task automatic waitQ(input logic [2:0] n);
        for (int i = 0; i < 400 && qCount !== n; i++) @(negedge mclk);
        if (qCount !== n) hang("queue level");
    endtask
    // length and address of the next memory access
    task automatic reqLen(output int len, output logic [15:0] addr);
        int i;
        // a fetch of the old stream still in flight after a branch is skipped
        for (i = 0; i < 100 && memReq === 1'b1; i++) @(negedge mclk);
        for (i = 0; i < 100 && memReq !== 1'b1; i++) @(negedge mclk);
        if (memReq !== 1'b1) hang("memory request");
        addr = memAddr;
        len = 0;
        while (memReq === 1'b1 && len < 20) begin
            len++;
            @(negedge mclk);
        end
    endtask
    task automatic branch(input logic [15:0] a);
        @(negedge mclk);
        branchReq = 1'b1;
        branchAddr = a;
        @(negedge mclk);
        branchReq = 1'b0;
    endtask
    task automatic setBus(input logic dis, input logic sp, input logic [2:0] cw,
                          input logic [2:0] dw);
        @(negedge mclk);
        busCtlWrite = 1'b1;
        busCtlDisable = dis;
        busCtlSplit = sp;
        busCtlCodeWait = cw;
        busCtlDataWait = dw;
        @(negedge mclk);
        busCtlWrite = 1'b0;
    endtask
    // request held until the acknowledge is seen, then dropped
    task automatic dataAccess(input logic we, input logic [15:0] a, input logic [7:0] wd,
                              output int len, output logic [7:0] rd);
        int i;
        len = 0;
        @(negedge mclk);
        dataReq = 1'b1;
        dataWe = we;
        dataAddr = a;
        dataWdata = wd;
        for (i = 0; i < 100 && dataAck !== 1'b1; i++) begin
            @(negedge mclk);
            if (memReq === 1'b1 && memAddr === a && memWe === we) len++;
        end
        if (dataAck !== 1'b1) hang("data acknowledge");
        rd = dataRdata;
        dataReq = 1'b0;
    endtask

    task automatic tResetFill();
        logic seen;
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        check(enabled, 1, "enabled after reset");
        check(qCount, 0, "queue empty after reset");
        @(negedge mclk);
        check(memReq, 1, "fetch starts on idle bus");
        check(memAddr, 16'h0000, "first fetch address");
        waitQ(6);
        check(qByte0, codeAt(16'h0000), "oldest byte");
        check(qByte1, codeAt(16'h0001), "second byte");
        seen = 1'b0;
        repeat (12) begin
            @(negedge mclk);
            seen |= (memReq === 1'b1);
        end
        check(seen, 0, "fetch with full queue");
    endtask
    task automatic tTakeTwo();
        int len;
        logic [15:0] a;
        @(negedge mclk);
        take = 1'b1;
        takeTwo = 1'b1;
        @(negedge mclk);
        take = 1'b0;
        takeTwo = 1'b0;
        check(qCount, 4, "two bytes taken");
        check(qByte0, codeAt(16'h0002), "head after take");
        reqLen(len, a);
        check(a, 16'h0006, "refetch next needed byte");
        check(len, 4, "reset wait count");
    endtask
    task automatic tBranchCache();
        int len;
        logic [15:0] a;
        branch(16'h0040);
        check(qCount, 0, "miss empties queue");
        reqLen(len, a);
        check(a, 16'h0040, "refetch at destination");
        waitQ(6);
        branch(16'h0040);
        check(qCount, 6, "hit fills queue at once");
        check(qByte0, codeAt(16'h0040), "hit byte 0");
        check(qByte1, codeAt(16'h0041), "hit byte 1");
        // a full queue fetches nothing, so one byte is consumed first
        @(negedge mclk);
        take = 1'b1;
        @(negedge mclk);
        take = 1'b0;
        reqLen(len, a);
        check(a, 16'h0046, "fetch after hit");
    endtask
    task automatic tEvict();
        logic [15:0] dest [4] = '{16'h0010, 16'h0020, 16'h0030, 16'h0050};
        foreach (dest[i]) begin
            branch(dest[i]);
            check(qCount, 0, "new destination misses");
            waitQ(6);
        end
        branch(16'h0020);
        check(qCount, 6, "recent entry still hits");
        branch(16'h0040);
        check(qCount, 0, "oldest entry replaced");
        waitQ(6);
    endtask
    task automatic tWaits();
        logic [2:0] cw [3] = '{3'h0, 3'h2, 3'h5};
        int expLen [3] = '{1, 2, 5};
        int len;
        logic [15:0] a;
        logic [7:0] rd;
        foreach (cw[i]) begin
            setBus(1'b0, 1'b0, cw[i], 3'h7);
            branch(16'h0060);
            reqLen(len, a);
            check(16'(len), 16'(expLen[i]), "code wait length");
        end
        setBus(1'b0, 1'b1, 3'h2, 3'h5);
        waitQ(6);
        dataAccess(1'b0, 16'hF0F0, 8'h00, len, rd);
        check(16'(len), 16'd5, "split data wait");
        check(rd, codeAt(16'hF0F0), "data read value");
        setBus(1'b0, 1'b0, 3'h3, 3'h5);
        dataAccess(1'b1, 16'hF0F1, 8'h3C, len, rd);
        check(16'(len), 16'd3, "shared data wait");
        dataAccess(1'b0, 16'hF0F1, 8'h00, len, rd);
        check(rd, 8'h3C, "write read back");
    endtask
    task automatic tDisable();
        setBus(1'b1, 1'b0, 3'h4, 3'h4);
        check(enabled, 0, "disabled by write");
        branch(16'h0040);
        check(qCount, 0, "no cache lookup when off");
        waitQ(1);
        repeat (20) @(negedge mclk);
        check(qCount, 1, "queue depth one when off");
        setBus(1'b0, 1'b0, 3'h4, 3'h4);
        check(enabled, 1, "enabled again");
    endtask
    task automatic tMcycle();
        int n;
        for (n = 0; n < 10 && mcycEn !== 1'b1; n++) @(negedge mclk);
        if (mcycEn !== 1'b1) hang("machine cycle");
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (mcycEn !== 1'b1 && n < 10);
        check(16'(n), 16'd4, "machine cycle length");
    endtask

    initial begin
        tResetFill();
        tTakeTwo();
        tBranchCache();
        tEvict();
        tWaits();
        tDisable();
        tMcycle();
        printVerdict();
    end
endmodule
